// [bench/i2c_host_model.sv]
`default_nettype none
module i2c_host_model
   import led_ramp_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus released, clock line high
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Ten clocks a phase stays above the two-clock filter minimum
   task automatic hold();
      repeat (10) @(posedge clk_sys);
      #1;
   endtask
   // Start (or repeated start) when first is 0, stop when first is 1
   task automatic cond(input logic first);
      sda_low = first;
      hold();
      scl = 1'b1;
      hold();
      sda_low = ~first;
      hold();
      if (!first) begin
         scl = 1'b0;
         hold();
      end
   endtask
   // Eight bits MSB first then a released ninth bit; data moves with clock low only
   task automatic put_byte(input logic [7:0] v, output logic [7:0] r, output logic ack);
      logic [8:0] o;
      logic [8:0] s;
      o = {v, 1'b1};
      s = 9'h000;
      for (int i = 8; i >= 0; i--) begin
         sda_low = ~o[i];
         hold();
         scl = 1'b1;
         hold();
         s = {s[7:0], sda_line};
         scl = 1'b0;
         hold();
      end
      r = s[8:1];
      ack = s[0];
   endtask
   // Address with write flag, register byte, one data byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic [2:0] k;
      cond(1'b0);
      put_byte({DEV_ADDR_DEF, 1'b0}, r, k[2]);
      put_byte(a, r, k[1]);
      put_byte(d, r, k[0]);
      cond(1'b1);
      ok = (k == 3'h0);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic       k;
      cond(1'b0);
      put_byte({DEV_ADDR_DEF, 1'b0}, r, k);
      put_byte(a, r, k);
      cond(1'b0);
      put_byte({DEV_ADDR_DEF, 1'b1}, r, k);
      put_byte(8'hFF, d, k); // Released last bit ends the read
      cond(1'b1);
   endtask
endmodule
`default_nettype wire

// [bench/led_ramp_properties.sv]
`default_nettype none
module led_ramp_properties
   import led_ramp_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              sys_rst,
   input wire logic              scl_i,
   input wire logic              sda_i,
   input wire logic              sda_o,
   input wire logic              sda_oe,
   input wire logic              analog_enable,
   input wire logic              feedback_mode,
   input wire logic              primary_sink_on,
   input wire logic              secondary_sink_on,
   input wire logic [CODE_W-1:0] primary_code,
   input wire logic [CODE_W-1:0] secondary_code,
   input wire logic [FRAC_W-1:0] primary_current_frac,
   input wire logic [FRAC_W-1:0] secondary_current_frac
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // Applied codes move one code at a time; the primary code then holds for at least eight more cycles
   property one_step(logic [CODE_W-1:0] c);
      $changed(c) |-> (c == $past(c) + 7'h01) || (c == $past(c) - 7'h01);
   endproperty
   a_prim_step: assert property (one_step(primary_code))
      else $error("primary code jumped");
   a_sec_step: assert property (one_step(secondary_code))
      else $error("secondary code jumped");
   a_prim_dwell: assert property ($changed(primary_code) |=> $stable(primary_code) [*8])
      else $error("primary steps too close");
   // Settled codes at both ends of the scale; code and fraction are registered in the same cycle
   a_zero_frac: assert property ($stable(secondary_code) && secondary_code == 7'h00
      |-> secondary_current_frac == 16'h0000) else $error("fraction not zero");
   a_full_frac: assert property ($stable(primary_code) && primary_code == 7'h7F
      |-> primary_current_frac == 16'hFFFF) else $error("fraction not full");
   // Fixed-voltage mode
   a_fixed_off: assert property (feedback_mode && $past(feedback_mode) |-> !secondary_sink_on)
      else $error("secondary on in fixed mode");
   a_fixed_analog: assert property (feedback_mode && $past(feedback_mode) |-> analog_enable)
      else $error("analog off in fixed mode");
   // Primary sink stays on until its fade has reached code zero
   a_fade_end: assert property ($fell(primary_sink_on) |-> primary_code == 7'h00)
      else $error("sink off before fade end");
   // Data line moves only while the serial clock is low
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data line moved with clock high");
   c_full: cover property (primary_code == 7'h7F);
   c_both: cover property (primary_sink_on && secondary_sink_on);
   c_fade: cover property ($fell(primary_sink_on));
endmodule
bind led_sink_brightness_ramp led_ramp_properties chk (.clk_sys, .sys_rst, .scl_i, .sda_i, .sda_o, .sda_oe,
   .analog_enable, .feedback_mode, .primary_sink_on, .secondary_sink_on, .primary_code, .secondary_code,
   .primary_current_frac, .secondary_current_frac);
`default_nettype wire

// [bench/led_sink_brightness_ramp_tb.sv]
`default_nettype none
module led_sink_brightness_ramp_tb import led_ramp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Short dwells keep the run small; fast dwell is fixed
   localparam int MID = 20;
   localparam int SLW = 30;
   localparam int SLST = 40;
   logic              clk_sys;
   logic              sys_rst;
   logic              scl;
   logic              sda_low;
   logic              sda_o;
   logic              sda_oe;
   logic              analog_enable;
   logic              feedback_mode;
   logic              primary_sink_on;
   logic              secondary_sink_on;
   logic [CODE_W-1:0] primary_code;
   logic [CODE_W-1:0] secondary_code;
   logic [FRAC_W-1:0] primary_current_frac;
   logic [FRAC_W-1:0] secondary_current_frac;
   wire               sda_line;
   int                errors;
   int                n_checks;
   int                n;
   logic [1:0]        rb [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
   int                dw [4] = '{RAMP_FAST_CYC, MID, SLW, SLST};
   // Open-drain line with pull-up
   assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   led_sink_brightness_ramp #(.MID_CYC(TMR_W'(MID)), .SLOW_CYC(TMR_W'(SLW)), .SLOWEST_CYC(TMR_W'(SLST))) dut (
      .clk_sys, .sys_rst, .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe, .analog_enable, .feedback_mode,
      .primary_sink_on, .secondary_sink_on, .primary_code, .secondary_code, .primary_current_frac,
      .secondary_current_frac);
   i2c_host_model host (.clk_sys, .sda_line, .scl, .sda_low);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      host.wr(a, d, ok);
      check("ack", 32'(ok), 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      host.rd(a, v);
      check("register", 32'(v), 32'(e));
   endtask
   // Bounded wait for an applied code; n keeps the cycles taken
   task automatic wait_code(input logic sec, input logic [6:0] v, input int lim);
      n = 0;
      while ((sec ? secondary_code : primary_code) !== v && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check("code", 32'(sec ? secondary_code : primary_code), 32'(v));
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Normal run is near 40000 cycles
   initial begin
      repeat (80000) @(posedge clk_sys);
      $display("[ERR] watchdog expected done seen hang");
      errors++;
      close_out();
   end
   initial begin
      errors = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(GC_ADDR, 8'hC0);
      rd(PL_ADDR, 8'hE0);
      rd(8'h20, UNMAPPED_READ);
      wr(GC_ADDR, 8'h20);
      rd(GC_ADDR, 8'hE0);
      check("fixed", 32'({analog_enable, feedback_mode, secondary_sink_on}), 32'h6);
      wr(GC_ADDR, 8'h00);
      check("analog", 32'(analog_enable), 32'h0);
      wr(SL_ADDR, 8'h03);
      rd(SL_ADDR, 8'h83);
      $display("test registers done");
      // Each dwell setting: time six steps, then fade to zero
      wr(PL_ADDR, 8'h0C);
      for (int i = 0; i < 4; i++) begin
         wr(GC_ADDR, {3'b000, rb[i], 3'b001});
         wait_code(1'b0, 7'h06, 4000);
         wait_code(1'b0, 7'h0C, 4000);
         check("dwell", 32'((n + 3) / 6), 32'(dw[i]));
         wr(GC_ADDR, {3'b000, rb[i], 3'b000});
         wait_code(1'b0, 7'h00, 7000);
         repeat (4) @(posedge clk_sys);
         check("fade", 32'({primary_sink_on, primary_current_frac}), 32'h0);
      end
      $display("test dwell done");
      // Unison: both sinks follow the primary level
      wr(GC_ADDR, 8'h15);
      wait_code(1'b0, 7'h0C, 1000);
      repeat (2) @(posedge clk_sys);
      check("unison", 32'({secondary_sink_on, secondary_code}), 32'h8C);
      wr(GC_ADDR, 8'h16);
      wait_code(1'b1, 7'h00, 1000);
      repeat (4) @(posedge clk_sys);
      check("unison off", 32'({primary_sink_on, secondary_sink_on, primary_code}), 32'h0);
      // Independent: secondary alone on its own level
      wr(GC_ADDR, 8'h12);
      wait_code(1'b1, 7'h03, 500);
      check("indep", 32'({primary_sink_on, primary_code}), 32'h0);
      wr(GC_ADDR, 8'h10);
      wait_code(1'b1, 7'h00, 500);
      $display("test modes done");
      // New level mid-ramp: old goal first, then back down
      wr(PL_ADDR, 8'h7F);
      wr(GC_ADDR, 8'h11);
      wr(PL_ADDR, 8'h01);
      wait_code(1'b0, 7'h7F, 3000);
      repeat (2) @(posedge clk_sys);
      check("full", 32'(primary_current_frac), 32'hFFFF);
      wait_code(1'b0, 7'h01, 3000);
      $display("test retarget done");
      close_out();
   end
endmodule
`default_nettype wire

// [hdl/led_ramp_pkg.sv]
`default_nettype none
package led_ramp_pkg;
   // Register map and reset values
   localparam logic [7:0] GC_ADDR        = 8'h10;
   localparam logic [7:0] PL_ADDR        = 8'hA0;
   localparam logic [7:0] SL_ADDR        = 8'hB0;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;
   localparam logic [6:0] DEV_ADDR_DEF   = 7'h36;
   localparam logic [5:0] GC_RESET       = 6'h00;
   localparam logic [1:0] GC_FIXED_ONES  = 2'h3;
   localparam logic [6:0] LEVEL_RESET    = 7'h60;
   localparam logic       LEVEL_TOP_READ = 1'b1;
   localparam logic [3:0] BYTE_BITS      = 4'h8;
   localparam logic [3:0] ACK_BIT        = 4'h9;

   // Ramp timing
   localparam int CLK_NS          = 25;
   localparam int RAMP_FAST_NS    = 12750;
   localparam int RAMP_MID_NS     = 3250000;
   localparam int RAMP_SLOW_NS    = 6500000;
   localparam int RAMP_SLOWEST_NS = 13000000;
   localparam int RAMP_FAST_CYC   = RAMP_FAST_NS / CLK_NS;
   localparam int RAMP_MID_CYC    = RAMP_MID_NS / CLK_NS;
   localparam int RAMP_SLOW_CYC   = RAMP_SLOW_NS / CLK_NS;
   localparam int RAMP_SLOWEST_CYC = RAMP_SLOWEST_NS / CLK_NS;
   localparam int TMR_W           = 20;
   localparam int CODE_W          = 7;
   localparam int FRAC_W          = 16;
   localparam int EXP_NUM         = 100000;
   localparam int EXP_DEN         = 105212;

   // Control register fields, bit 5 down to bit 0
   typedef struct packed {
      logic fixed_voltage_mode;
      logic ramp_rate_high_bit;
      logic ramp_rate_low_bit;
      logic unison_select;
      logic secondary_sink_enable;
      logic primary_sink_enable;
   } general_control_s;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_RX   = 3'b010,
      BUS_TX   = 3'b100
   } bus_state_e;

   // Full scale divided by a fixed ratio per code below the top
   function automatic logic [FRAC_W-1:0] exp_frac(input int code);
      logic [63:0] v;
      v = 64'h0000_0000_FFFF_0000;
      for (int i = 127; i > code; i--) begin
         v = (v * 64'(EXP_NUM)) / 64'(EXP_DEN);
      end
      return (code == 0) ? 16'h0000 : v[31:16];
   endfunction
endpackage
`default_nettype wire

// [hdl/led_sink_brightness_ramp.sv]
`default_nettype none
module led_sink_brightness_ramp
   import led_ramp_pkg::*;
#(
   parameter logic [6:0]       DEV_ADDR       = DEV_ADDR_DEF,
   parameter logic [TMR_W-1:0] MID_CYC        = TMR_W'(RAMP_MID_CYC),
   parameter logic [TMR_W-1:0] SLOW_CYC       = TMR_W'(RAMP_SLOW_CYC),
   parameter logic [TMR_W-1:0] SLOWEST_CYC    = TMR_W'(RAMP_SLOWEST_CYC)
) (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output var  logic              sda_o,
   output var  logic              sda_oe,
   output var  logic              analog_enable,
   output var  logic              feedback_mode,
   output var  logic              primary_sink_on,
   output var  logic              secondary_sink_on,
   output var  logic [CODE_W-1:0] primary_code,
   output var  logic [CODE_W-1:0] secondary_code,
   output var  logic [FRAC_W-1:0] primary_current_frac,
   output var  logic [FRAC_W-1:0] secondary_current_frac
);

   // Pin synchronisers: a level counts once stages two and three agree
   logic [2:0] scl_s_q, sda_s_q;
   logic       scl_f_q, scl_f_d, sda_f_q, sda_f_d;

   always_comb begin
      scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
      sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
         scl_f_q <= scl_f_d;
         sda_f_q <= sda_f_d;
      end
   end

   // Bus events on the filtered lines
   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = ~scl_f_q & scl_f_d;
   assign scl_fall  = scl_f_q & ~scl_f_d;
   assign bus_start = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
   assign bus_stop  = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

   // Serial slave state and the register file it owns
   bus_state_e       st_q, st_d;
   logic [3:0]       cnt_q, cnt_d;
   logic [7:0]       sh_q, sh_d;
   logic [7:0]       ptr_q, ptr_d;
   logic             first_q, first_d;
   logic             regph_q, regph_d;
   logic             rnw_q, rnw_d;
   logic             ack_q, ack_d;
   logic             nack_q, nack_d;
   logic             oe_q, oe_d;
   general_control_s gc_q, gc_d;
   logic [6:0]       pl_q, pl_d;
   logic [6:0]       sl_q, sl_d;
   logic [7:0]       rd_byte;

   // Read view: fixed ones above the control fields and the level codes
   always_comb begin
      case (ptr_q)
         GC_ADDR: rd_byte = {GC_FIXED_ONES, gc_q};
         PL_ADDR: rd_byte = {LEVEL_TOP_READ, pl_q};
         SL_ADDR: rd_byte = {LEVEL_TOP_READ, sl_q};
         default: rd_byte = UNMAPPED_READ;
      endcase
   end

   // Next state of the slave; stop and start override any byte in flight
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ptr_d   = ptr_q;
      first_d = first_q;
      regph_d = regph_q;
      rnw_d   = rnw_q;
      ack_d   = ack_q;
      nack_d  = nack_q;
      oe_d    = oe_q;
      gc_d    = gc_q;
      pl_d    = pl_q;
      sl_d    = sl_q;
      if (bus_stop) begin
         st_d  = BUS_IDLE;
         ack_d = 1'b0;
         oe_d  = 1'b0;
      end else if (bus_start) begin
         st_d    = BUS_RX;
         cnt_d   = 4'h0;
         first_d = 1'b1;
         ack_d   = 1'b0;
         oe_d    = 1'b0;
      end else begin
         case (st_q)
            BUS_IDLE: begin
               oe_d = 1'b0;
            end
            BUS_RX: begin
               if (scl_rise && !ack_q) begin
                  sh_d  = {sh_q[6:0], sda_f_q};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && ack_q) begin
                  // Acknowledge ends; a read address hands over to transmit
                  ack_d = 1'b0;
                  oe_d  = 1'b0;
                  cnt_d = 4'h0;
                  if (rnw_q) begin
                     st_d = BUS_TX;
                     sh_d = rd_byte;
                     oe_d = ~rd_byte[7];
                  end
               end else if (scl_fall && cnt_q == BYTE_BITS) begin
                  if (first_q) begin
                     if (sh_q[7:1] == DEV_ADDR) begin
                        first_d = 1'b0;
                        rnw_d   = sh_q[0];
                        regph_d = ~sh_q[0];
                        ack_d   = 1'b1;
                        oe_d    = 1'b1;
                     end else begin
                        st_d = BUS_IDLE;
                     end
                  end else if (regph_q) begin
                     ptr_d   = sh_q;
                     regph_d = 1'b0;
                     ack_d   = 1'b1;
                     oe_d    = 1'b1;
                  end else begin
                     ack_d = 1'b1;
                     oe_d  = 1'b1;
                     case (ptr_q)
                        GC_ADDR: gc_d = general_control_s'(sh_q[5:0]);
                        PL_ADDR: pl_d = sh_q[6:0];
                        SL_ADDR: sl_d = sh_q[6:0];
                        default: ;
                     endcase
                  end
               end
            end
            BUS_TX: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == BYTE_BITS) begin
                     nack_d = sda_f_q;
                  end
               end else if (scl_fall) begin
                  if (cnt_q == BYTE_BITS) begin
                     oe_d = 1'b0;
                  end else if (cnt_q == ACK_BIT) begin
                     // Master ack repeats the same register; nack ends the read
                     if (nack_q) begin
                        st_d = BUS_IDLE;
                     end else begin
                        sh_d  = rd_byte;
                        cnt_d = 4'h0;
                        oe_d  = ~rd_byte[7];
                     end
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            default: begin
               st_d = BUS_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q    <= BUS_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         ptr_q   <= 8'h00;
         first_q <= 1'b0;
         regph_q <= 1'b0;
         rnw_q   <= 1'b0;
         ack_q   <= 1'b0;
         nack_q  <= 1'b0;
         oe_q    <= 1'b0;
         gc_q    <= general_control_s'(GC_RESET);
         pl_q    <= LEVEL_RESET;
         sl_q    <= LEVEL_RESET;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         ptr_q   <= ptr_d;
         first_q <= first_d;
         regph_q <= regph_d;
         rnw_q   <= rnw_d;
         ack_q   <= ack_d;
         nack_q  <= nack_d;
         oe_q    <= oe_d;
         gc_q    <= gc_d;
         pl_q    <= pl_d;
         sl_q    <= sl_d;
      end
   end

   // Sink selection from the mode bits
   logic [1:0]             sink_en;
   logic [CODE_W-1:0]      sink_src [2];
   logic [TMR_W-1:0]       dwell_cyc;

   always_comb begin
      sink_en[0]  = gc_q.primary_sink_enable;
      sink_en[1]  = ~gc_q.fixed_voltage_mode &
                    (gc_q.unison_select ? gc_q.primary_sink_enable
                                        : gc_q.secondary_sink_enable);
      sink_src[0] = pl_q;
      sink_src[1] = gc_q.unison_select ? pl_q : sl_q;
      case ({gc_q.ramp_rate_high_bit, gc_q.ramp_rate_low_bit})
         2'b00:   dwell_cyc = TMR_W'(RAMP_FAST_CYC);
         2'b10:   dwell_cyc = MID_CYC;
         2'b01:   dwell_cyc = SLOW_CYC;
         default: dwell_cyc = SLOWEST_CYC;
      endcase
   end

   // Exponential current table, fixed at elaboration
   logic [FRAC_W-1:0] exp_lut [128];
   for (genvar k = 0; k < 128; k++) begin : g_lut
      assign exp_lut[k] = exp_frac(k);
   end

   // One ramp engine per sink, each with its own dwell timer
   logic [CODE_W-1:0] applied [2];
   for (genvar s = 0; s < 2; s++) begin : g_ramp
      logic [CODE_W-1:0] app_q, app_d, goal_q, goal_d, tgt;
      logic [TMR_W-1:0]  tmr_q, tmr_d;
      logic              busy_q, busy_d;

      // A running ramp keeps its goal unless the sink was switched off
      always_comb begin
         tgt    = sink_en[s] ? sink_src[s] : 7'h00;
         goal_d = goal_q;
         app_d  = app_q;
         tmr_d  = (tmr_q != 20'h00000) ? tmr_q - 20'h00001 : tmr_q;
         if (!busy_q || (!sink_en[s] && goal_q != 7'h00)) begin
            goal_d = tgt;
         end
         if (app_q != goal_d && tmr_q == 20'h00000) begin
            app_d = (app_q < goal_d) ? app_q + 7'h01 : app_q - 7'h01;
            tmr_d = dwell_cyc - 20'h00001;
         end
         busy_d = (app_d != goal_d);
      end

      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            app_q  <= 7'h00;
            goal_q <= 7'h00;
            tmr_q  <= 20'h00000;
            busy_q <= 1'b0;
         end else begin
            app_q  <= app_d;
            goal_q <= goal_d;
            tmr_q  <= tmr_d;
            busy_q <= busy_d;
         end
      end

      assign applied[s] = app_q;
   end

   // Registered outputs; a sink stays on while it fades down to zero, except the secondary in fixed-voltage mode
   logic              an_d, pon_d, son_d;
   logic [FRAC_W-1:0] pfr_d, sfr_d;

   always_comb begin
      an_d  = gc_q.primary_sink_enable | gc_q.secondary_sink_enable | gc_q.fixed_voltage_mode;
      pon_d = sink_en[0] | (applied[0] != 7'h00);
      son_d = ~gc_q.fixed_voltage_mode & (sink_en[1] | (applied[1] != 7'h00));
      pfr_d = exp_lut[applied[0]];
      sfr_d = exp_lut[applied[1]];
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sda_o                  <= 1'b0;
         sda_oe                 <= 1'b0;
         analog_enable          <= 1'b0;
         feedback_mode          <= 1'b0;
         primary_sink_on        <= 1'b0;
         secondary_sink_on      <= 1'b0;
         primary_code           <= 7'h00;
         secondary_code         <= 7'h00;
         primary_current_frac   <= 16'h0000;
         secondary_current_frac <= 16'h0000;
      end else begin
         sda_o                  <= 1'b0;
         sda_oe                 <= oe_d;
         analog_enable          <= an_d;
         feedback_mode          <= gc_q.fixed_voltage_mode;
         primary_sink_on        <= pon_d;
         secondary_sink_on      <= son_d;
         primary_code           <= applied[0];
         secondary_code         <= applied[1];
         primary_current_frac   <= pfr_d;
         secondary_current_frac <= sfr_d;
      end
   end

endmodule
`default_nettype wire
